// ==== hdl/scd_defs.vh ====
// scd_defs.vh: constants for the adapter command decoder
// assumes: included by bare name from the decoder and its bench; the stack memory does not include it
`ifndef SCD_DEFS_VH
`define SCD_DEFS_VH
// ------------------------------------------------------------
// register word offsets (byte address = offset, word aligned)
// ------------------------------------------------------------
`define SCD_A_STACK0 6'h00
`define SCD_A_STACK3 6'h0c
`define SCD_A_CMD 6'h10
`define SCD_A_STATUS 6'h14
`define SCD_A_STATEXT 6'h18
`define SCD_A_AUX 6'h1c
`define SCD_A_DMAADR 6'h20
`define SCD_A_EVENT 6'h24
`define SCD_A_TESTRES 6'h28
`define SCD_A_PROGRESS 6'h2c
// ------------------------------------------------------------
// command register fields and op codes
// ------------------------------------------------------------
`define SCD_OP_HI 15
`define SCD_OP_LO 12
`define SCD_TAG_HI 4
`define SCD_TAG_LO 0
`define SCD_OP_SEND 4'h0
`define SCD_OP_BUF 4'h1
`define SCD_OP_SELFTEST 4'h4
`define SCD_OP_WRAP 4'h5
`define SCD_OP_CONT 4'h7
// ------------------------------------------------------------
// stack byte 0 fields
// ------------------------------------------------------------
`define SCD_B0_ID_HI 2
`define SCD_B0_ID_LO 0
`define SCD_B0_DIR 3
`define SCD_B0_XFER 4
`define SCD_B0_HALT 5
`define SCD_B0_BYTESEL 2
// ------------------------------------------------------------
// status register fields and codes
// ------------------------------------------------------------
`define SCD_ST_BUSY 7
`define SCD_ST_INTV 6
`define SCD_ST_DONE 5
`define SCD_TAG_SELFTEST 5'h1f
`define SCD_CODE_TESTS_DONE 8'h0f
`define SCD_ERR_A 8'h41
`define SCD_ERR_B 8'h42
`define SCD_ERR_C 8'h44
`define SCD_WRAP_HI 4
`define SCD_WRAP_LO 0
// ------------------------------------------------------------
// buffer geometry
// ------------------------------------------------------------
`define SCD_SECT_BYTES 16'h0200
`define SCD_SECT_LAST 7'h7f
`define SCD_WORDS_PER_SECT 9'h100
`endif

// ==== hdl/scd_stack_mem.v ====
// scd_stack_mem.v: 16-byte parameter stack, four bytes per word
// assumes: one clock, writes by word index with byte enables
`timescale 1ns/1ps
module scd_stack_mem (
  // clock
  input wire clk_i,
  input wire ce_i,
  // write port
  input wire we_i,
  input wire [1:0] waddr_i,
  input wire [3:0] sel_i,
  input wire [31:0] wdata_i,
  // clear
  input wire clr_i,
  // read port
  input wire [1:0] raddr_i,
  output reg [31:0] rdata_o,
  // all bytes flat
  output wire [127:0] flat_o
);
  reg [31:0] mem_reg [0:3];
  integer k;
  genvar b;
  always @(posedge clk_i) begin
    if (ce_i) begin
      if (clr_i) begin
        for (k = 0; k < 4; k = k + 1) begin
          mem_reg[k] <= 32'h00000000;
        end
      end else if (we_i) begin
        for (k = 0; k < 4; k = k + 1) begin
          if (sel_i[k]) begin
            mem_reg[waddr_i][k*8 +: 8] <= wdata_i[k*8 +: 8];
          end
        end
      end
      rdata_o <= mem_reg[raddr_i];
    end
  end
  generate
    for (b = 0; b < 4; b = b + 1) begin : g_flat
      assign flat_o[b*32 +: 32] = mem_reg[b];
    end
  endgenerate
endmodule

// ==== hdl/scd_decoder.v ====
// scd_decoder.v: adapter command decoder with wishbone register slave
// assumes: one clock, synchronous reset; stack byte n sits at byte address n
//
// Operation
// - send command takes target id from stack byte 0 bits 2..0
// - byte 0 bit 3 picks data direction, 0 out, 1 in
// - byte 0 bit 4 set means data phase, bytes 1 and 3 used
// - byte 0 bit 5 halts transfer after intermediate interrupt until continue
// - buffer has 128 sections of 512 bytes; byte 1 gives start section
// - transfer past section 127 wraps to section 0
// - zero granularity gives one completion interrupt only
// - granularity g interrupts every 512*g bytes; none if beyond length
// - only the logical unit field of the cdb is used
// - completion sets status bit 5 and target status; failure clears it
// - error 41, 42, 44 put target status in extension, else next address
// - buffer command moves 512-byte sections by dma, one interrupt at end
// - buffer byte 0 bit 3 is dma direction, bit 2 byte count mode
// - byte 6 length: bytes over two, or blocks minus one
// - dma address from bytes 2..4 high to low; byte 1 ignored
// - self test runs at once, resets bus, clears stack and registers
// - self test tag 1f, busy held, fail code then 0f on reread
// - wrap test reports zero on pass, wrap number in bits 12..8 on fail
// - command write outside halt holds op code and tag and sets busy
`timescale 1ns/1ps
`include "scd_defs.vh"
module scd_decoder #(
  parameter WRAP_CODE_W = 5
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // wishbone slave
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [5:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  // target side
  output reg [2:0] target_id_o,
  output reg data_in_o,
  output reg transfer_present_o,
  output reg halt_after_interrupt_o,
  output reg [2:0] lun_o,
  output reg scsi_reset_o,
  output reg data_strobe_o,
  // dma side
  output reg dma_req_o,
  output reg dma_read_buf_o,
  output reg [23:0] dma_addr_o,
  // interrupt event
  output reg irq_o
);
  // ------------------------------------------------------------
  // states
  // ------------------------------------------------------------
  localparam S_IDLE = 3'h0;
  localparam S_SEND = 3'h1;
  localparam S_HALT = 3'h2;
  localparam S_BUF = 3'h3;
  localparam S_TEST = 3'h4;
  localparam S_DONE = 3'h5;
  reg [2:0] state_reg;
  reg [2:0] state_next;
  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [15:0] cmd_reg;
  reg [15:0] status_reg;
  reg [15:0] statext_reg;
  reg [15:0] aux_reg;
  reg [7:0] testres_reg;
  reg [7:0] target_status_reg;
  reg [7:0] err_code_reg;
  reg fail_reg;
  reg ev_data_reg;
  reg ev_target_done_reg;
  reg fail_reported_reg;
  reg [6:0] sect_reg;
  reg [8:0] word_reg;
  reg [15:0] words_left_reg;
  reg [15:0] gran_cnt_reg;
  reg [7:0] gran_reg;
  reg [15:0] words_total_reg;
  wire [127:0] stack_flat;
  wire [31:0] stack_rdata;
  wire bus_req;
  wire wr_stack;
  wire wr_cmd;
  wire wr_event;
  wire stack_clr;
  wire [7:0] sb0;
  wire [7:0] sb1;
  wire [7:0] sb3;
  wire [7:0] sb5;
  wire [7:0] sb6;
  wire err_ext_status;
  // ------------------------------------------------------------
  // stack storage
  // ------------------------------------------------------------
  assign bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr_stack = bus_req & wb_we_i & (wb_adr_i <= `SCD_A_STACK3) & ~status_reg[`SCD_ST_BUSY];
  assign wr_cmd = bus_req & wb_we_i & (wb_adr_i == `SCD_A_CMD) & ~status_reg[`SCD_ST_BUSY];
  assign wr_event = bus_req & wb_we_i & (wb_adr_i == `SCD_A_EVENT);
  assign stack_clr = rst_i | (state_reg == S_TEST);
  scd_stack_mem u_stack (
    .clk_i(clk_i),
    .ce_i(ce_i),
    .we_i(wr_stack),
    .waddr_i(wb_adr_i[3:2]),
    .sel_i(wb_sel_i),
    .wdata_i(wb_dat_i),
    .clr_i(stack_clr),
    .raddr_i(wb_adr_i[3:2]),
    .rdata_o(stack_rdata),
    .flat_o(stack_flat)
  );
  assign sb0 = stack_flat[7:0];
  assign sb1 = stack_flat[15:8];
  assign sb3 = stack_flat[31:24];
  assign sb5 = stack_flat[47:40];
  assign sb6 = stack_flat[55:48];
  assign err_ext_status = (err_code_reg == `SCD_ERR_A) | (err_code_reg == `SCD_ERR_B) |
                          (err_code_reg == `SCD_ERR_C);
  // ------------------------------------------------------------
  // control state machine
  // ------------------------------------------------------------
  always @* begin
    state_next = state_reg;
    case (state_reg)
      S_IDLE: begin
        if (status_reg[`SCD_ST_BUSY]) begin
          case (cmd_reg[`SCD_OP_HI:`SCD_OP_LO])
            `SCD_OP_SEND: state_next = S_SEND;
            `SCD_OP_BUF: state_next = S_BUF;
            `SCD_OP_SELFTEST: state_next = S_TEST;
            `SCD_OP_WRAP: state_next = S_TEST;
            default: state_next = S_DONE;
          endcase
        end
      end
      S_SEND: begin
        if (ev_target_done_reg) begin
          state_next = S_DONE;
        end else if (ev_data_reg & (gran_reg != 8'h00) & (gran_cnt_reg == 16'h0001) &
                     (words_left_reg != 16'h0001) & halt_after_interrupt_o) begin
          state_next = S_HALT;
        end
      end
      S_HALT: begin
        if (wr_cmd & (wb_dat_i[`SCD_OP_HI:`SCD_OP_LO] == `SCD_OP_CONT)) begin
          state_next = S_SEND;
        end
      end
      S_BUF: begin
        if (words_left_reg == 16'h0000) begin
          state_next = S_DONE;
        end
      end
      S_TEST: state_next = S_DONE;
      S_DONE: state_next = S_IDLE;
      default: state_next = S_IDLE;
    endcase
  end
  // ------------------------------------------------------------
  // datapath and registers
  // ------------------------------------------------------------
  always @(posedge clk_i) begin
    if (rst_i) begin
      state_reg <= S_IDLE;
      cmd_reg <= 16'h0000;
      status_reg <= 16'h0000;
      statext_reg <= 16'h0000;
      aux_reg <= 16'h0000;
      testres_reg <= 8'h00;
      target_status_reg <= 8'h00;
      err_code_reg <= 8'h00;
      fail_reg <= 1'b0;
      ev_data_reg <= 1'b0;
      ev_target_done_reg <= 1'b0;
      fail_reported_reg <= 1'b0;
      sect_reg <= 7'h00;
      word_reg <= 9'h000;
      words_left_reg <= 16'h0000;
      words_total_reg <= 16'h0000;
      gran_cnt_reg <= 16'h0000;
      gran_reg <= 8'h00;
      target_id_o <= 3'h0;
      data_in_o <= 1'b0;
      transfer_present_o <= 1'b0;
      halt_after_interrupt_o <= 1'b0;
      lun_o <= 3'h0;
      scsi_reset_o <= 1'b0;
      data_strobe_o <= 1'b0;
      dma_req_o <= 1'b0;
      dma_read_buf_o <= 1'b0;
      dma_addr_o <= 24'h000000;
      irq_o <= 1'b0;
      wb_ack_o <= 1'b0;
      wb_dat_o <= 32'h00000000;
    end else if (ce_i) begin
      state_reg <= state_next;
      wb_ack_o <= bus_req;
      irq_o <= 1'b0;
      scsi_reset_o <= 1'b0;
      data_strobe_o <= 1'b0;
      ev_data_reg <= 1'b0;
      ev_target_done_reg <= 1'b0;
      // software events and target results
      if (wr_event) begin
        ev_data_reg <= wb_dat_i[0];
        ev_target_done_reg <= wb_dat_i[1];
        fail_reg <= wb_dat_i[2];
        target_status_reg <= wb_dat_i[15:8];
        err_code_reg <= wb_dat_i[23:16];
      end
      if (bus_req & wb_we_i & (wb_adr_i == `SCD_A_TESTRES)) begin
        testres_reg <= wb_dat_i[7:0];
      end
      if (wr_cmd & (state_reg != S_HALT)) begin
        cmd_reg <= wb_dat_i[15:0];
        status_reg[`SCD_ST_BUSY] <= 1'b1;
        if (wb_dat_i[`SCD_OP_HI:`SCD_OP_LO] == `SCD_OP_SELFTEST) begin
          status_reg[`SCD_TAG_HI:`SCD_TAG_LO] <= `SCD_TAG_SELFTEST;
        end else begin
          status_reg[`SCD_TAG_HI:`SCD_TAG_LO] <= wb_dat_i[`SCD_TAG_HI:`SCD_TAG_LO];
        end
      end
      // status read: failing code, then tests-done code on reread
      if (bus_req & ~wb_we_i) begin
        case (wb_adr_i)
          `SCD_A_STACK0, 6'h04, 6'h08, `SCD_A_STACK3: wb_dat_o <= stack_rdata;
          `SCD_A_CMD: wb_dat_o <= {16'h0000, cmd_reg};
          `SCD_A_STATUS: begin
            wb_dat_o <= {16'h0000, status_reg};
            status_reg[`SCD_ST_INTV] <= 1'b0;
            if (fail_reported_reg) begin
              status_reg[15:8] <= `SCD_CODE_TESTS_DONE;
              fail_reported_reg <= 1'b0;
            end
          end
          `SCD_A_STATEXT: wb_dat_o <= {16'h0000, statext_reg};
          `SCD_A_AUX: wb_dat_o <= {16'h0000, aux_reg};
          `SCD_A_DMAADR: wb_dat_o <= {8'h00, dma_addr_o};
          `SCD_A_PROGRESS: wb_dat_o <= {9'h000, state_reg, words_left_reg, sect_reg[3:0]};
          default: wb_dat_o <= 32'h00000000;
        endcase
      end
      case (state_reg)
        S_IDLE: begin
          if (status_reg[`SCD_ST_BUSY]) begin
            words_total_reg <= 16'h0000;
            if (cmd_reg[`SCD_OP_HI:`SCD_OP_LO] == `SCD_OP_SEND) begin
              target_id_o <= sb0[`SCD_B0_ID_HI:`SCD_B0_ID_LO];
              data_in_o <= sb0[`SCD_B0_DIR];
              transfer_present_o <= sb0[`SCD_B0_XFER];
              halt_after_interrupt_o <= sb0[`SCD_B0_HALT];
              lun_o <= sb5[7:5];
              sect_reg <= sb1[6:0];
              word_reg <= 9'h000;
              gran_reg <= sb0[`SCD_B0_XFER] ? sb3 : 8'h00;
              gran_cnt_reg <= {sb3, 8'h00};
              words_left_reg <= {stack_flat[71:64], stack_flat[79:72]} << 8;
              status_reg[`SCD_ST_BUSY] <= 1'b0;
            end else if (cmd_reg[`SCD_OP_HI:`SCD_OP_LO] == `SCD_OP_BUF) begin
              dma_read_buf_o <= sb0[`SCD_B0_DIR];
              dma_addr_o <= {stack_flat[23:16], stack_flat[31:24], stack_flat[39:32]};
              sect_reg <= sb5[6:0];
              word_reg <= 9'h000;
              if (sb0[`SCD_B0_BYTESEL]) begin
                words_left_reg <= {8'h00, sb6};
              end else begin
                words_left_reg <= {sb6 + 8'h01, 8'h00};
              end
              status_reg[`SCD_ST_BUSY] <= 1'b0;
            end
          end
        end
        S_SEND: begin
          if (ev_data_reg) begin
            data_strobe_o <= 1'b1;
            words_left_reg <= words_left_reg - 16'h0001;
            words_total_reg <= words_total_reg + 16'h0001;
            if (word_reg == `SCD_WORDS_PER_SECT - 9'h001) begin
              word_reg <= 9'h000;
              sect_reg <= (sect_reg == `SCD_SECT_LAST) ? 7'h00 : sect_reg + 7'h01;
            end else begin
              word_reg <= word_reg + 9'h001;
            end
            if (gran_reg != 8'h00) begin
              if (gran_cnt_reg == 16'h0001) begin
                gran_cnt_reg <= {gran_reg, 8'h00};
                if (words_left_reg != 16'h0001) begin
                  irq_o <= 1'b1;
                  status_reg[`SCD_ST_INTV] <= 1'b1;
                end
              end else begin
                gran_cnt_reg <= gran_cnt_reg - 16'h0001;
              end
            end
          end
          if (ev_target_done_reg) begin
            gran_cnt_reg <= {gran_reg, 8'h00};
          end
        end
        S_BUF: begin
          dma_req_o <= (words_left_reg != 16'h0000);
          if (words_left_reg != 16'h0000) begin
            words_left_reg <= words_left_reg - 16'h0001;
            dma_addr_o <= dma_addr_o + {23'h000000, dma_req_o};
            if (word_reg == `SCD_WORDS_PER_SECT - 9'h001) begin
              word_reg <= 9'h000;
              sect_reg <= (sect_reg == `SCD_SECT_LAST) ? 7'h00 : sect_reg + 7'h01;
            end else begin
              word_reg <= word_reg + 9'h001;
            end
          end
        end
        S_TEST: begin
          scsi_reset_o <= 1'b1;
          statext_reg <= 16'h0000;
          aux_reg <= 16'h0000;
          sect_reg <= 7'h00;
          status_reg[`SCD_ST_BUSY] <= 1'b1;
        end
        S_DONE: begin
          dma_req_o <= 1'b0;
          irq_o <= 1'b1;
          status_reg[`SCD_ST_INTV] <= 1'b1;
          status_reg[`SCD_ST_BUSY] <= 1'b0;
          case (cmd_reg[`SCD_OP_HI:`SCD_OP_LO])
            `SCD_OP_SELFTEST: begin
              status_reg[`SCD_ST_DONE] <= 1'b0;
              status_reg[15:8] <= (testres_reg == 8'h00) ? `SCD_CODE_TESTS_DONE : testres_reg;
              fail_reported_reg <= (testres_reg != 8'h00);
            end
            `SCD_OP_WRAP: begin
              status_reg[`SCD_ST_DONE] <= 1'b0;
              status_reg[15:8] <= {{(8-WRAP_CODE_W){1'b0}}, testres_reg[`SCD_WRAP_HI:`SCD_WRAP_LO]};
            end
            `SCD_OP_SEND: begin
              status_reg[`SCD_ST_DONE] <= ~fail_reg;
              status_reg[15:8] <= fail_reg ? err_code_reg : target_status_reg;
              if (fail_reg & err_ext_status) begin
                statext_reg <= {8'h00, target_status_reg};
              end else begin
                statext_reg <= {1'b0, sect_reg, word_reg[7:0]};
              end
            end
            default: begin
              status_reg[`SCD_ST_DONE] <= 1'b0;
              status_reg[15:8] <= 8'h00;
              statext_reg <= {1'b0, sect_reg, word_reg[7:0]};
            end
          endcase
        end
        default: begin
        end
      endcase
    end
  end
endmodule

// ==== test/scd_decoder_checker.sv ====
// scd_decoder_checker.sv: port assertions for the command decoder
// assumes: bound to scd_decoder, one clock, sync reset
`timescale 1ns/1ps
module scd_decoder_checker #(
  parameter WRAP_CODE_W = 5
) (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  input wire ce_i,
  // wishbone
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire [31:0] wb_dat_o,
  input wire wb_ack_o,
  // events and dma
  input wire irq_o,
  input wire scsi_reset_o,
  input wire dma_req_o,
  input wire dma_read_buf_o,
  input wire [23:0] dma_addr_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  a_ack_after_take: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=> wb_ack_o)
    else $error("no ack one cycle after request");
  a_ack_one_cycle: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_needs_req: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_read_data_hold: assert property ($changed(wb_dat_o) |-> wb_ack_o)
    else $error("read data moved without ack");
  a_quiet_after_reset: assert property ($fell(rst_i) |-> !wb_ack_o && !irq_o && !dma_req_o && !scsi_reset_o)
    else $error("output active after reset");
  a_irq_single_pulse: assert property (irq_o |=> !irq_o)
    else $error("interrupt longer than one cycle");
  a_dma_no_irq: assert property (dma_req_o |-> !irq_o)
    else $error("interrupt before dma finished");
  a_dma_addr_step: assert property (dma_req_o && $past(dma_req_o) && $changed(dma_addr_o)
    |-> dma_addr_o == $past(dma_addr_o) + 24'h1)
    else $error("dma address not stepping by one");
  a_dma_dir_hold: assert property (dma_req_o && $past(dma_req_o) |-> $stable(dma_read_buf_o))
    else $error("dma direction changed mid transfer");
  // ----------------------------------------
  // covers
  // ----------------------------------------
  c_irq: cover property (irq_o);
  c_dma: cover property ($rose(dma_req_o));
  c_bus_reset: cover property (scsi_reset_o);
endmodule
bind scd_decoder scd_decoder_checker #(.WRAP_CODE_W(WRAP_CODE_W)) u_chk (.clk_i(clk_i), .rst_i(rst_i),
  .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
  .irq_o(irq_o), .scsi_reset_o(scsi_reset_o), .dma_req_o(dma_req_o), .dma_read_buf_o(dma_read_buf_o),
  .dma_addr_o(dma_addr_o));

// ==== test/scd_target_model.sv ====
// scd_target_model.sv: far side model counting target and dma activity
// assumes: samples decoder outputs on the rising clock edge
`timescale 1ns/1ps
module scd_target_model (
  // clock and reset
  input wire clk_i,
  input wire rst_i,
  // decoder outputs
  input wire irq_i,
  input wire data_strobe_i,
  input wire scsi_reset_i,
  input wire dma_req_i,
  input wire dma_read_buf_i,
  input wire [23:0] dma_addr_i,
  // counts
  output reg [15:0] irq_count_o,
  output reg [15:0] word_count_o,
  output reg [15:0] reset_count_o,
  output reg [15:0] dma_words_o,
  output reg [23:0] first_addr_o,
  output reg first_dir_o
);
  reg req_reg;
  reg [23:0] addr_reg;
  always @(posedge clk_i) begin
    if (rst_i) begin
      irq_count_o <= 16'h0;
      word_count_o <= 16'h0;
      reset_count_o <= 16'h0;
      dma_words_o <= 16'h0;
      first_addr_o <= 24'h0;
      first_dir_o <= 1'b0;
    end else begin
      irq_count_o <= irq_count_o + {15'h0, irq_i};
      word_count_o <= word_count_o + {15'h0, data_strobe_i};
      reset_count_o <= reset_count_o + {15'h0, scsi_reset_i};
      if (dma_req_i && !req_reg) begin
        dma_words_o <= 16'h1;
        first_addr_o <= dma_addr_i;
        first_dir_o <= dma_read_buf_i;
      end else if (dma_req_i && dma_addr_i != addr_reg) begin
        dma_words_o <= dma_words_o + 16'h1;
      end
    end
    req_reg <= dma_req_i;
    addr_reg <= dma_addr_i;
  end
endmodule

// ==== test/scd_decoder_tb.sv ====
// scd_decoder_tb.sv: self-checking bench for the command decoder
// assumes: decoder, checker and target model compiled first
`timescale 1ns/1ps
`include "scd_defs.vh"
module scd_decoder_tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic ce_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  wire [31:0] wb_dat_o;
  wire wb_ack_o, data_in_o, transfer_present_o, halt_after_interrupt_o, scsi_reset_o, data_strobe_o;
  wire dma_req_o, dma_read_buf_o, irq_o, first_dir;
  wire [2:0] target_id_o, lun_o;
  wire [23:0] dma_addr_o, first_addr;
  wire [15:0] irq_cnt, word_cnt, rst_cnt, dma_words;
  integer mismatches = 0;
  integer samples_checked = 0;
  logic [31:0] q;
  always #12.5 clk_i = ~clk_i;
  scd_decoder dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(ce_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .target_id_o(target_id_o), .data_in_o(data_in_o), .lun_o(lun_o),
    .transfer_present_o(transfer_present_o), .halt_after_interrupt_o(halt_after_interrupt_o),
    .scsi_reset_o(scsi_reset_o), .data_strobe_o(data_strobe_o), .dma_req_o(dma_req_o),
    .dma_read_buf_o(dma_read_buf_o), .dma_addr_o(dma_addr_o), .irq_o(irq_o));
  scd_target_model far (.clk_i(clk_i), .rst_i(rst_i), .irq_i(irq_o), .data_strobe_i(data_strobe_o),
    .scsi_reset_i(scsi_reset_o), .dma_req_i(dma_req_o), .dma_read_buf_i(dma_read_buf_o),
    .dma_addr_i(dma_addr_o), .irq_count_o(irq_cnt), .word_count_o(word_cnt), .reset_count_o(rst_cnt),
    .dma_words_o(dma_words), .first_addr_o(first_addr), .first_dir_o(first_dir));
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic close_out;
    $display("mismatches %0d samples_checked %0d", mismatches, samples_checked);
    if (mismatches == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic wb(input logic we, input logic [5:0] a, input logic [31:0] d);
    integer n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_sel_i <= 4'hf;
    wb_dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 40);
    if (wb_ack_o !== 1'b1) begin
      mismatches++;
      close_out();
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask
  task automatic wait_status(input logic [31:0] e, input logic [31:0] m);
    integer k;
    k = 0;
    do begin
      wb(1'b0, `SCD_A_STATUS, 32'h0);
      k++;
    end while ((q & m) !== e && k < 100);
    chk("status", e, q & m);
    if ((q & m) !== e)
      close_out();
  endtask
  task automatic issue(input logic [31:0] w0, w1, w2, w3, cmd);
    wb(1'b1, 6'h00, w0);
    wb(1'b1, 6'h04, w1);
    wb(1'b1, 6'h08, w2);
    wb(1'b1, 6'h0c, w3);
    wb(1'b1, `SCD_A_CMD, cmd);
    wait_status(32'h0, 32'h80);
  endtask
  task automatic wait_irq(input logic [15:0] n);
    integer k;
    for (k = 0; k < 2000 && irq_cnt !== n; k++)
      @(posedge clk_i);
    chk("irq count", {16'h0, n}, {16'h0, irq_cnt});
    if (irq_cnt !== n)
      close_out();
  endtask
  task automatic words(input integer cnt);
    integer i;
    for (i = 0; i < cnt; i++)
      wb(1'b1, `SCD_A_EVENT, 32'h1);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic sc_reset;
    wb(1'b0, `SCD_A_STATUS, 32'h0);
    chk("status reset", 32'h0, q);
    wb(1'b1, 6'h3c, 32'hffffffff);
    wb(1'b0, 6'h3c, 32'h0);
    chk("unmapped", 32'h0, q);
  endtask
  task automatic sc_send;
    logic [15:0] n0;
    logic [15:0] w0;
    n0 = irq_cnt;
    w0 = word_cnt;
    issue(32'h01007f3d, 32'h00006000, 32'h00000200, 32'h0, 32'h00000003);
    chk("target", 32'h17b, {23'h0, target_id_o, data_in_o, transfer_present_o, halt_after_interrupt_o, lun_o});
    words(256);
    wait_irq(n0 + 16'h1);
    wb(1'b0, `SCD_A_PROGRESS, 32'h0);
    chk("halted", 32'h00201000, q);
    wb(1'b1, `SCD_A_CMD, 32'h00007003);
    words(256);
    wb(1'b1, `SCD_A_EVENT, 32'h00000202);
    chk("words", 32'h200, {16'h0, word_cnt - w0});
    wait_status(32'h00000223, 32'hffffffbf);
    wb(1'b0, `SCD_A_STATEXT, 32'h0);
    chk("next address", 32'h00000100, q);
  endtask
  task automatic sc_fail;
    issue(32'h00000022, 32'h00002000, 32'h0, 32'h0, 32'h00000004);
    chk("target", 32'h089, {23'h0, target_id_o, data_in_o, transfer_present_o, halt_after_interrupt_o, lun_o});
    wb(1'b1, `SCD_A_EVENT, 32'h00410806);
    wait_status(32'h00004104, 32'hffffffbf);
    wb(1'b0, `SCD_A_STATEXT, 32'h0);
    chk("ext status", 32'h00000008, q);
  endtask
  task automatic sc_buf(input logic [31:0] w0, w1, input logic [15:0] nw, input logic dir);
    logic [15:0] n0;
    n0 = irq_cnt;
    issue(w0, w1, 32'h0, 32'h0, 32'h00001002);
    wait_irq(n0 + 16'h1);
    chk("dma words", {16'h0, nw}, {16'h0, dma_words});
    chk("dma addr", 32'h00123456, {8'h0, first_addr});
    chk("dma dir", {31'h0, dir}, {31'h0, first_dir});
  endtask
  task automatic sc_tests;
    logic [15:0] r0;
    logic [4:0] w;
    integer i;
    r0 = rst_cnt;
    wb(1'b1, `SCD_A_TESTRES, 32'h0);
    issue(32'h0, 32'h0, 32'h0, 32'h0, 32'h00004005);
    wait_status(32'h00000f1f, 32'hffffff1f);
    chk("bus reset", 32'h1, {31'h0, rst_cnt != r0});
    wb(1'b0, `SCD_A_STATEXT, 32'h0);
    chk("ext zero", 32'h0, q);
    wb(1'b0, `SCD_A_AUX, 32'h0);
    chk("aux zero", 32'h0, q);
    wb(1'b1, `SCD_A_TESTRES, 32'h00000033);
    issue(32'h0, 32'h0, 32'h0, 32'h0, 32'h00004005);
    chk("test fail code", 32'h33, {24'h0, q[15:8]});
    wb(1'b0, `SCD_A_STATUS, 32'h0);
    chk("tests done", 32'h0f, {24'h0, q[15:8]});
    for (i = 0; i < 2; i++) begin
      w = (i == 0) ? 5'h09 : 5'h00;
      wb(1'b1, `SCD_A_TESTRES, {27'h0, w});
      issue(32'h0, 32'h0, 32'h0, 32'h0, 32'h00005001);
      chk("wrap code", {27'h0, w}, {24'h0, q[15:8]});
    end
  endtask
  initial begin
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    sc_reset();
    sc_send();
    sc_fail();
    sc_buf(32'h3412ff08, 32'h00000356, 16'h0100, 1'b1);
    sc_buf(32'h3412ff04, 32'h00100356, 16'h0010, 1'b0);
    sc_tests();
    close_out();
  end
endmodule
